// File: src/timer_compare_pkg.sv
// constants and types shared by the output compare timer block
package timer_compare_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_COUNTER = 8'h00;
  localparam logic [7:0] OFF_COMPARE = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_FLAG = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_ASYNC = 8'h14;

  // timer_control_a fields
  localparam int CTL_RUN = 7;
  localparam int CTL_FORCE = 6;
  localparam int CTL_COM_LSB = 4;
  localparam int CTL_WGM_LSB = 0;

  // flag, mask and async_status_register fields
  localparam int FLAG_MATCH = 0;
  localparam int MASK_MATCH = 0;
  localparam int AST_EXTERNAL_CLOCK_ENABLE = 6;
  localparam int AST_AS0 = 5;
  localparam int AST_CNT_BUSY = 4;
  localparam int AST_CMP_BUSY = 3;
  localparam int AST_CTL_BUSY = 1;

  // reset values
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // count limits
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // async clock edges before a temporary register is latched
  localparam logic [1:0] ASYNC_EDGES = 2'h2;

  // compare output mode encodings
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WGM_NORMAL = 2'h0,
    WGM_PHASE_PWM = 2'h1,
    WGM_CLEAR_ON_MATCH = 2'h2,
    WGM_FAST_PWM = 2'h3
  } wave_mode_t;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } count_dir_t;

endpackage : timer_compare_pkg

// File: src/sync_two_flop.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
module sync_two_flop #(
  parameter int W = 1
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [W-1:0] d, // asynchronous level in
  output logic [W-1:0] q // synchronised level
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule : sync_two_flop

// File: src/async_transfer_slot.sv
// temporary register latched into its destination after async clock edges
`timescale 1ns/100ps
module async_transfer_slot (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic load, // software write while async
  input wire logic [7:0] load_data, // written value
  input wire logic abort, // clock source switched
  input wire logic async_edge, // rising edge of async clock
  output logic busy, // transfer pending
  output logic commit, // destination loads this cycle
  output logic [7:0] data // value to load
);
  logic busy_q;
  logic [7:0] data_q;
  logic [1:0] edges_q;

  assign commit = busy_q & async_edge & ~load & ~abort &
                  (edges_q == timer_compare_pkg::ASYNC_EDGES - 2'h1); // RL15
  assign busy = busy_q;
  assign data = data_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_q <= 1'b0;
      data_q <= 8'h00;
      edges_q <= 2'h0;
    end
    else if (abort)
    begin
      busy_q <= 1'b0;
      edges_q <= 2'h0;
    end
    else if (load)
    begin
      data_q <= load_data;
      busy_q <= 1'b1; // RL24
      edges_q <= 2'h0;
    end
    else if (commit)
    begin
      busy_q <= 1'b0; // RL24
      edges_q <= 2'h0;
    end
    else if (busy_q && async_edge)
    begin
      edges_q <= edges_q + 2'h1;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  load_busy_a: assert property (load && !abort |=> busy_q) // RL24
    else $error("busy not set after load");
  done_commit_a: assert property ($fell(busy_q) && !$past(abort) |-> $past(commit)) // RL16
    else $error("busy cleared without transfer");
endmodule : async_transfer_slot

// File: src/timer_compare_unit.sv
// output compare unit of an 8-bit timer with async register transfer
// Contract
// RL1 - compare counter with compare value continuously
// RL2 - match sets flag one timer cycle later
// RL3 - enabled flag requests interrupt, service clears
// RL4 - writing one clears the match flag
// RL5 - PWM double buffers compare, updates at top
// RL6 - CPU writes reach buffer or active register
// RL7 - force strobe acts like match, no flag
// RL8 - counter write blocks next cycle's match
// RL9 - match sets, clears or toggles output state
// RL10 - output mode change takes effect immediately
// RL11 - nonzero mode overrides pin, direction kept
// RL12 - output state kept across mode changes
// RL13 - software sets output state before enabling pin
// RL14 - software avoids writing counter equal compare
// RL15 - async writes pass separate temporary registers
// RL16 - status bits show pending transfers
// RL17 - software waits before rewriting async register
// RL18 - async writes disable compare while pending; here only pending counter and compare writes do, not control writes
// RL19 - clock switch may corrupt timer registers
// RL20 - software follows safe clock switch order
// RL21 - CPU clock above four times crystal
// RL22 - software waits for update before power save
// RL23 - async select picks system or async clock
// RL24 - counter busy set on write, hardware clears
// RL25 - flag and output state reset to zero
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module timer_compare_unit (
  input wire logic aclk, // 125 MHz system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic async_clock_pin, // low frequency crystal clock
  input wire logic external_clock_pin, // external async clock
  input wire logic irq_ack, // interrupt serviced pulse
  output logic compare_irq, // compare interrupt request
  input wire logic port_out_value, // port output value
  input wire logic compare_pin_direction, // port direction, 1 output
  output logic compare_pin_out, // pin output value
  output logic compare_pin_oe_n // pin drive enable, active low
);
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] cnt_q, cnt_d, ocr_q, ocr_buf_q;
  logic [1:0] com_q, wgm_q;
  logic run_q, as0_q, external_clock_enable_q, flag_q, irq_en_q, oc_q, oc_d;
  logic match_q, block_q, sel_prev_q;
  timer_compare_pkg::count_dir_t dir_q, dir_d;
  logic [1:0] pins_sync;

  // bus decode
  wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_ok = wr_fire & w_lane_q;
  wire [7:0] wa = {aw_addr_q[7:2], 2'b00};
  wire [7:0] ra = {araddr[7:2], 2'b00};
  wire wr_cnt = wr_ok & (wa == timer_compare_pkg::OFF_COUNTER);
  wire wr_cmp = wr_ok & (wa == timer_compare_pkg::OFF_COMPARE);
  wire wr_ctl = wr_ok & (wa == timer_compare_pkg::OFF_CONTROL);
  wire wr_flag = wr_ok & (wa == timer_compare_pkg::OFF_FLAG);
  wire wr_mask = wr_ok & (wa == timer_compare_pkg::OFF_MASK);
  wire wr_ast = wr_ok & (wa == timer_compare_pkg::OFF_ASYNC);
  wire wr_hit = (wa == timer_compare_pkg::OFF_COUNTER) | (wa == timer_compare_pkg::OFF_COMPARE) |
                (wa == timer_compare_pkg::OFF_CONTROL) | (wa == timer_compare_pkg::OFF_FLAG) |
                (wa == timer_compare_pkg::OFF_MASK) | (wa == timer_compare_pkg::OFF_ASYNC);
  wire ar_fire = arvalid & ~rvalid_q;

  // clock source and timer tick
  sync_two_flop #(.W(2)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({external_clock_pin, async_clock_pin}),
    .q(pins_sync)
  );
  wire sel_clk = external_clock_enable_q ? pins_sync[1] : pins_sync[0]; // RL23
  wire async_edge = sel_clk & ~sel_prev_q;
  wire clk_edge = as0_q ? async_edge : 1'b1; // RL23
  wire timer_tick = clk_edge & run_q;

  // temporary registers for async writes
  wire abort = wr_ast & (w_data_q[timer_compare_pkg::AST_AS0] != as0_q); // RL19
  wire cnt_busy, cmp_busy, ctl_busy, cnt_commit, cmp_commit, ctl_commit;
  wire [7:0] cnt_slot, cmp_slot, ctl_slot;
  async_transfer_slot u_cnt_slot (
    .aclk(aclk), .aresetn(aresetn), .load(wr_cnt & as0_q), .load_data(w_data_q), .abort(abort),
    .async_edge(async_edge), .busy(cnt_busy), .commit(cnt_commit), .data(cnt_slot)
  );
  async_transfer_slot u_cmp_slot (
    .aclk(aclk), .aresetn(aresetn), .load(wr_cmp & as0_q), .load_data(w_data_q), .abort(abort),
    .async_edge(async_edge), .busy(cmp_busy), .commit(cmp_commit), .data(cmp_slot)
  );
  async_transfer_slot u_ctl_slot (
    .aclk(aclk), .aresetn(aresetn), .load(wr_ctl & as0_q), .load_data(w_data_q), .abort(abort),
    .async_edge(async_edge), .busy(ctl_busy), .commit(ctl_commit), .data(ctl_slot)
  );

  wire cnt_load = as0_q ? cnt_commit : wr_cnt; // RL15
  wire [7:0] cnt_val = as0_q ? cnt_slot : w_data_q;
  wire cmp_load = as0_q ? cmp_commit : wr_cmp; // RL15
  wire [7:0] cmp_val = as0_q ? cmp_slot : w_data_q;
  wire ctl_load = as0_q ? ctl_commit : wr_ctl; // RL15
  wire [7:0] ctl_val = as0_q ? ctl_slot : w_data_q;

  // compare and waveform events
  wire pwm = wgm_q[0];
  wire at_max = cnt_q == timer_compare_pkg::COUNT_MAX;
  wire match_now = (cnt_q == ocr_q) & ~block_q & ~(as0_q & (cnt_busy | cmp_busy)); // RL1 RL8 RL18
  wire match_hit = timer_tick & match_q; // RL2
  wire top_evt = timer_tick & at_max & pwm; // RL5
  wire bottom_evt = timer_tick & at_max & (wgm_q == timer_compare_pkg::WGM_FAST_PWM);
  wire force_evt = wr_ctl & w_data_q[timer_compare_pkg::CTL_FORCE] &
                   ~w_data_q[timer_compare_pkg::CTL_WGM_LSB]; // RL7
  wire flag_clr = (wr_flag & w_data_q[timer_compare_pkg::FLAG_MATCH]) | irq_ack; // RL3 RL4

  function automatic logic match_action(input logic oc, input logic [1:0] com, input logic [1:0] wgm,
                                        input logic down);
    logic r;
    r = oc;
    case (wgm)
      timer_compare_pkg::WGM_NORMAL, timer_compare_pkg::WGM_CLEAR_ON_MATCH:
      begin
        if (com == timer_compare_pkg::COM_TOGGLE) r = ~oc;
        else if (com == timer_compare_pkg::COM_CLEAR) r = 1'b0;
        else if (com == timer_compare_pkg::COM_SET) r = 1'b1;
      end
      timer_compare_pkg::WGM_FAST_PWM:
      begin
        if (com == timer_compare_pkg::COM_CLEAR) r = 1'b0;
        else if (com == timer_compare_pkg::COM_SET) r = 1'b1;
      end
      default:
      begin
        if (com == timer_compare_pkg::COM_CLEAR) r = down;
        else if (com == timer_compare_pkg::COM_SET) r = ~down;
      end
    endcase
    return r;
  endfunction : match_action

  always_comb
  begin
    oc_d = oc_q; // RL12
    if (force_evt)
      oc_d = match_action(oc_q, w_data_q[timer_compare_pkg::CTL_COM_LSB +: 2],
                          timer_compare_pkg::WGM_NORMAL, 1'b0); // RL7
    else if (match_hit)
      oc_d = match_action(oc_q, com_q, wgm_q, dir_q == timer_compare_pkg::DIR_DOWN); // RL9
    else if (bottom_evt && com_q == timer_compare_pkg::COM_CLEAR)
      oc_d = 1'b1;
    else if (bottom_evt && com_q == timer_compare_pkg::COM_SET)
      oc_d = 1'b0;
  end

  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (cnt_load)
      cnt_d = cnt_val;
    else if (timer_tick)
    begin
      case (wgm_q)
        timer_compare_pkg::WGM_PHASE_PWM:
        begin
          case (dir_q)
            timer_compare_pkg::DIR_UP:
            begin
              cnt_d = at_max ? cnt_q - 8'h01 : cnt_q + 8'h01;
              if (at_max) dir_d = timer_compare_pkg::DIR_DOWN;
            end
            default:
            begin
              cnt_d = (cnt_q == timer_compare_pkg::COUNT_BOTTOM) ? cnt_q + 8'h01 : cnt_q - 8'h01;
              if (cnt_q == timer_compare_pkg::COUNT_BOTTOM) dir_d = timer_compare_pkg::DIR_UP;
            end
          endcase
        end
        timer_compare_pkg::WGM_CLEAR_ON_MATCH:
          cnt_d = (cnt_q == ocr_q) ? timer_compare_pkg::COUNT_BOTTOM : cnt_q + 8'h01;
        default:
          cnt_d = cnt_q + 8'h01;
      endcase
    end
  end

  // timer state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= timer_compare_pkg::CNT_RESET; // RL25
      dir_q <= timer_compare_pkg::DIR_UP;
      oc_q <= 1'b0; // RL25
      flag_q <= 1'b0; // RL25
      match_q <= 1'b0;
      block_q <= 1'b0;
      sel_prev_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      oc_q <= oc_d;
      flag_q <= match_hit | (flag_q & ~flag_clr); // RL2 RL3 RL4
      if (timer_tick) match_q <= match_now; // RL1
      if (cnt_load) block_q <= 1'b1; // RL8
      else if (timer_tick) block_q <= 1'b0; // RL8
      sel_prev_q <= sel_clk;
    end
  end

  // software visible registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ocr_q <= timer_compare_pkg::CMP_RESET;
      ocr_buf_q <= timer_compare_pkg::CMP_RESET;
      com_q <= timer_compare_pkg::CTL_RESET[timer_compare_pkg::CTL_COM_LSB +: 2];
      wgm_q <= timer_compare_pkg::CTL_RESET[timer_compare_pkg::CTL_WGM_LSB +: 2];
      run_q <= 1'b0;
      irq_en_q <= 1'b0;
      as0_q <= 1'b0;
      external_clock_enable_q <= 1'b0;
    end
    else
    begin
      if (cmp_load) ocr_buf_q <= cmp_val; // RL6
      if (cmp_load && !pwm) ocr_q <= cmp_val; // RL5 RL6
      else if (top_evt) ocr_q <= ocr_buf_q; // RL5
      if (ctl_load)
      begin
        com_q <= ctl_val[timer_compare_pkg::CTL_COM_LSB +: 2]; // RL10
        wgm_q <= ctl_val[timer_compare_pkg::CTL_WGM_LSB +: 2];
        run_q <= ctl_val[timer_compare_pkg::CTL_RUN];
      end
      if (wr_mask) irq_en_q <= w_data_q[timer_compare_pkg::MASK_MATCH];
      if (wr_ast)
      begin
        as0_q <= w_data_q[timer_compare_pkg::AST_AS0];
        external_clock_enable_q <= w_data_q[timer_compare_pkg::AST_EXTERNAL_CLOCK_ENABLE];
      end
    end
  end

  assign compare_irq = flag_q & irq_en_q; // RL3
  assign compare_pin_out = (com_q != timer_compare_pkg::COM_OFF) ? oc_q : port_out_value; // RL11
  assign compare_pin_oe_n = ~compare_pin_direction; // RL11

  // read mux
  wire [7:0] ast_val = {1'b0, external_clock_enable_q, as0_q, cnt_busy, cmp_busy, 1'b0, ctl_busy, 1'b0}; // RL16
  wire [7:0] ctl_rd = {run_q, 1'b0, com_q, 2'b00, wgm_q};
  wire rd_hit = (ra == timer_compare_pkg::OFF_COUNTER) | (ra == timer_compare_pkg::OFF_COMPARE) |
                (ra == timer_compare_pkg::OFF_CONTROL) | (ra == timer_compare_pkg::OFF_FLAG) |
                (ra == timer_compare_pkg::OFF_MASK) | (ra == timer_compare_pkg::OFF_ASYNC);
  wire [7:0] rd_byte = (ra == timer_compare_pkg::OFF_COUNTER) ? cnt_q :
                       (ra == timer_compare_pkg::OFF_COMPARE) ? ocr_buf_q :
                       (ra == timer_compare_pkg::OFF_CONTROL) ? ctl_rd :
                       (ra == timer_compare_pkg::OFF_FLAG) ? {7'h00, flag_q} :
                       (ra == timer_compare_pkg::OFF_MASK) ? {7'h00, irq_en_q} :
                       (ra == timer_compare_pkg::OFF_ASYNC) ? ast_val : 8'h00;

  // AXI4-Lite handshakes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= timer_compare_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= timer_compare_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      if (awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (wr_fire) aw_full_q <= 1'b0;
      if (wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        w_data_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
      else if (wr_fire) w_full_q <= 1'b0;
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? timer_compare_pkg::RESP_OKAY : timer_compare_pkg::RESP_SLVERR;
      end
      else if (bready) bvalid_q <= 1'b0;
      if (ar_fire)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= rd_hit ? timer_compare_pkg::RESP_OKAY : timer_compare_pkg::RESP_SLVERR;
      end
      else if (rready) rvalid_q <= 1'b0;
    end
  end

  assign awready = ~aw_full_q;
  assign wready = ~w_full_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = ~rvalid_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence match_seen;
    timer_tick && match_now;
  endsequence
  sequence next_tick_hit;
    timer_tick && match_q;
  endsequence

  flag_delay_a: assert property (match_seen ##[1:8] next_tick_hit |=> flag_q) // RL2
    else $error("flag not set one timer cycle after match");
  flag_cause_a: assert property ($rose(flag_q) |-> $past(timer_tick && match_q)) // RL2
    else $error("flag set without a registered match");
  irq_ack_a: assert property (irq_ack && !match_hit |=> !flag_q && !compare_irq) // RL3
    else $error("serviced interrupt did not clear flag");
  flag_w1c_a: assert property (wr_flag && w_data_q[timer_compare_pkg::FLAG_MATCH] && !match_hit |=> !flag_q) // RL4
    else $error("write one did not clear flag");
  load_block_a: assert property (cnt_load ##1 timer_tick |=> !match_q) // RL8
    else $error("match not blocked after counter write");
  buffer_hold_a: assert property (pwm && cmp_load && !top_evt |=> ocr_q == $past(ocr_q)) // RL5
    else $error("active compare changed outside top in pwm");
  force_noflag_a: assert property (force_evt && !match_hit && !cnt_load && !timer_tick && !irq_ack |=>
                                   flag_q == $past(flag_q) && cnt_q == $past(cnt_q)) // RL7
    else $error("force strobe touched flag or counter");
  mode_now_a: assert property (ctl_load && ctl_val[timer_compare_pkg::CTL_COM_LSB +: 2] != timer_compare_pkg::COM_OFF
                               |=> compare_pin_out == oc_q) // RL10
    else $error("output mode change not immediate");
  async_off_a: assert property (as0_q && (cnt_busy || cmp_busy) |-> !match_now) // RL18
    else $error("compare active during async write");
  keep_oc_a: assert property (ctl_load && !match_hit && !bottom_evt && !force_evt |=> oc_q == $past(oc_q)) // RL12
    else $error("output state lost on mode change");
endmodule : timer_compare_unit

// File: tb/port_pin_model.sv
// port pin partner: port value and direction registers and the pad
`timescale 1ns/100ps
module port_pin_model (
  input wire logic aclk, // system clock
  input wire logic value_req, // software port value
  input wire logic dir_req, // software direction
  input wire logic pin_out, // pad drive value
  input wire logic pin_oe_n, // pad drive enable, active low
  output logic port_out_value, // port register
  output logic compare_pin_direction, // direction register
  output logic pin_level // level seen on the pad
);
  always_ff @(posedge aclk)
  begin
    port_out_value <= value_req;
    compare_pin_direction <= dir_req;
  end
  // pull-up holds the pad high when nobody drives it
  assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule : port_pin_model

// File: tb/testbench.sv
// self-checking bench for the output compare timer unit
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, compare_irq, compare_pin_out, compare_pin_oe_n;
  logic [1:0] bresp, rresp;
  logic async_clock_pin = 1'b0, irq_ack = 1'b0, value_req = 1'b0, dir_req = 1'b0;
  logic port_out_value, compare_pin_direction, pin_level;
  logic [31:0] rd;
  logic [1:0] rs, bs;
  logic [7:0] cmp_v, cnt_v;
  int fail_count = 0, compares = 0, seed = 32'h6ff977ab, k;
  always #4 aclk = ~aclk;
  timer_compare_unit i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .async_clock_pin(async_clock_pin),
    .external_clock_pin(1'b0), .irq_ack(irq_ack), .compare_irq(compare_irq), .port_out_value(port_out_value),
    .compare_pin_direction(compare_pin_direction), .compare_pin_out(compare_pin_out),
    .compare_pin_oe_n(compare_pin_oe_n));
  port_pin_model i_pins (.aclk(aclk), .value_req(value_req), .dir_req(dir_req), .pin_out(compare_pin_out),
    .pin_oe_n(compare_pin_oe_n), .port_out_value(port_out_value),
    .compare_pin_direction(compare_pin_direction), .pin_level(pin_level));
  function automatic logic exp_pin(input logic [1:0] com, input logic st, input logic port);
    return (com != timer_compare_pkg::COM_OFF) ? st : port;
  endfunction : exp_pin
  function automatic logic [31:0] ctl(input logic run, input logic frc, input logic [1:0] com,
    input logic [1:0] wgm);
    return {24'h00_0000, run, frc, com, 2'b00, wgm};
  endfunction : ctl
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic a_ok, w_ok, a_dn, w_dn, b_ok;
    a_dn = 1'b0;
    w_dn = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a_dn && w_dn))
    begin
      @(negedge aclk);
      a_ok = !a_dn && awready;
      w_ok = !w_dn && wready;
      @(posedge aclk);
      if (a_ok) begin awvalid <= 1'b0; a_dn = 1'b1; end
      if (w_ok) begin wvalid <= 1'b0; w_dn = 1'b1; end
    end
    do
    begin
      @(negedge aclk);
      b_ok = bvalid;
      bs = bresp;
      @(posedge aclk);
    end while (!b_ok);
    bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ok = arready;
      @(posedge aclk);
    end while (!ok);
    arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!ok);
    rready <= 1'b0;
  endtask : rdr
  task automatic wait_irq();
    int n;
    n = 0;
    while (compare_irq !== 1'b1 && n < 300)
    begin
      @(negedge aclk);
      n++;
    end
    `CHK("irq raised", 1'b1, compare_irq)
  endtask : wait_irq
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial
  begin
    #400000;
    fail_count++;
    give_verdict();
  end
  initial
  begin
    logic [7:0] offs [6];
    offs = '{timer_compare_pkg::OFF_COUNTER, timer_compare_pkg::OFF_COMPARE, timer_compare_pkg::OFF_CONTROL,
      timer_compare_pkg::OFF_FLAG, timer_compare_pkg::OFF_MASK, timer_compare_pkg::OFF_ASYNC};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i])
    begin
      rdr(offs[i], rd, rs);
      `CHK("reset value", 32'h0000_0000, rd)
    end
    rdr(8'h40, rd, rs);
    `CHK("unmapped resp", timer_compare_pkg::RESP_SLVERR, rs)
    wr(8'h40, 32'h0000_00ff);
    `CHK("unmapped wresp", timer_compare_pkg::RESP_SLVERR, bs)
    // force in normal mode before the pin becomes an output
    wr(timer_compare_pkg::OFF_CONTROL, ctl(1'b0, 1'b1, timer_compare_pkg::COM_SET, timer_compare_pkg::WGM_NORMAL));
    `CHK("forced pin", exp_pin(timer_compare_pkg::COM_SET, 1'b1, port_out_value), compare_pin_out)
    rdr(timer_compare_pkg::OFF_FLAG, rd, rs);
    `CHK("force no flag", 32'h0000_0000, rd)
    rdr(timer_compare_pkg::OFF_COUNTER, rd, rs);
    `CHK("force no reload", 32'h0000_0000, rd)
    @(posedge aclk);
    dir_req <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK("pin driven", 1'b0, compare_pin_oe_n)
    `CHK("pad level", 1'b1, pin_level)
    wr(timer_compare_pkg::OFF_CONTROL, ctl(1'b0, 1'b0, timer_compare_pkg::COM_OFF, timer_compare_pkg::WGM_FAST_PWM));
    `CHK("port value", exp_pin(timer_compare_pkg::COM_OFF, 1'b1, 1'b0), compare_pin_out)
    wr(timer_compare_pkg::OFF_COMPARE, 32'h0000_005a);
    rdr(timer_compare_pkg::OFF_COMPARE, rd, rs);
    `CHK("buffered compare", 32'h0000_005a, rd)
    wr(timer_compare_pkg::OFF_CONTROL, ctl(1'b0, 1'b0, timer_compare_pkg::COM_SET,
      timer_compare_pkg::WGM_CLEAR_ON_MATCH));
    `CHK("state kept", 1'b1, compare_pin_out)
    // compare match: toggle, flag, interrupt, two ways of clearing
    cmp_v = 8'h20 + 8'($unsigned($random(seed)) % 200);
    wr(timer_compare_pkg::OFF_COMPARE, {24'h00_0000, cmp_v});
    wr(timer_compare_pkg::OFF_COUNTER, {24'h00_0000, cmp_v - 8'h10});
    wr(timer_compare_pkg::OFF_MASK, 32'h0000_0001);
    for (k = 0; k < 2; k++)
    begin
      wr(timer_compare_pkg::OFF_CONTROL, ctl(1'b1, 1'b0, timer_compare_pkg::COM_TOGGLE,
        timer_compare_pkg::WGM_NORMAL));
      wait_irq();
      `CHK("toggled pin", 1'(k[0]), compare_pin_out)
      wr(timer_compare_pkg::OFF_CONTROL, ctl(1'b0, 1'b0, timer_compare_pkg::COM_TOGGLE,
        timer_compare_pkg::WGM_NORMAL));
      rdr(timer_compare_pkg::OFF_FLAG, rd, rs);
      `CHK("flag set", 32'h0000_0001, rd)
      if (k == 0)
      begin
        @(posedge aclk);
        irq_ack <= 1'b1;
        @(posedge aclk);
        irq_ack <= 1'b0;
      end
      else
        wr(timer_compare_pkg::OFF_FLAG, 32'h0000_0001);
      rdr(timer_compare_pkg::OFF_FLAG, rd, rs);
      `CHK("flag cleared", 32'h0000_0000, rd)
      `CHK("irq low", 1'b0, compare_irq)
    end
    // counter written equal to compare while stopped and while running: next tick blocked
    wr(timer_compare_pkg::OFF_COUNTER, {24'h00_0000, cmp_v});
    wr(timer_compare_pkg::OFF_CONTROL, ctl(1'b1, 1'b0, timer_compare_pkg::COM_OFF, timer_compare_pkg::WGM_NORMAL));
    wr(timer_compare_pkg::OFF_COUNTER, {24'h00_0000, cmp_v});
    wr(timer_compare_pkg::OFF_CONTROL, ctl(1'b0, 1'b0, timer_compare_pkg::COM_OFF, timer_compare_pkg::WGM_NORMAL));
    rdr(timer_compare_pkg::OFF_FLAG, rd, rs);
    `CHK("blocked match", 32'h0000_0000, rd)
    // async transfer through temporary registers
    wr(timer_compare_pkg::OFF_MASK, 32'h0000_0000);
    wr(timer_compare_pkg::OFF_ASYNC, 32'h0000_0020);
    cnt_v = 8'($random(seed));
    cmp_v = 8'($random(seed));
    wr(timer_compare_pkg::OFF_COUNTER, {24'h00_0000, cnt_v});
    wr(timer_compare_pkg::OFF_COMPARE, {24'h00_0000, cmp_v});
    wr(timer_compare_pkg::OFF_CONTROL, 32'h0000_0000);
    rdr(timer_compare_pkg::OFF_ASYNC, rd, rs);
    `CHK("busy bits", 32'h0000_003a, rd)
    repeat (8)
    begin
      repeat (5) @(posedge aclk);
      async_clock_pin <= ~async_clock_pin;
    end
    repeat (6) @(posedge aclk);
    rdr(timer_compare_pkg::OFF_ASYNC, rd, rs);
    `CHK("busy cleared", 32'h0000_0020, rd)
    rdr(timer_compare_pkg::OFF_COUNTER, rd, rs);
    `CHK("counter latched", {24'h00_0000, cnt_v}, rd)
    rdr(timer_compare_pkg::OFF_COMPARE, rd, rs);
    `CHK("compare latched", {24'h00_0000, cmp_v}, rd)
    wr(timer_compare_pkg::OFF_FLAG, 32'h0000_0001);
    give_verdict();
  end
endmodule : testbench
